// File: hw/qd_consts.svh
// Constants for the quad converter two-wire update port
`ifndef QD_CONSTS_SVH
`define QD_CONSTS_SVH

// ============================================================
// Address byte
`define QD_ADDR_FIXED    5'h13
`define QD_BCAST_ADDR    8'h90
`define QD_HS_CODE       5'h01
`define QD_RW_READ       1'h1

// ============================================================
// Control byte fields and reset value
`define QD_CTL_RESET     8'h00
`define QD_CTL_EXT_HI    7
`define QD_CTL_EXT_LO    6
`define QD_CTL_MODE_HI   5
`define QD_CTL_MODE_LO   4
`define QD_CTL_PICK_HI   2
`define QD_CTL_PICK_LO   1
`define QD_CTL_PD        0

// ============================================================
// Byte framing in SCL rising edges
`define QD_BYTE_BITS     4'h8
`define QD_ACK_RISES     4'h9
`define QD_UPDATE_RISES  5'h12

// ============================================================
// Timing: spike widths in ns, counts derived at 8 ns per cycle
`define QD_CLK_NS        8
`define QD_SPIKE_FS_NS   50
`define QD_SPIKE_HS_NS   10
`define QD_FLT_FS_CYC    3'(((`QD_SPIKE_FS_NS / `QD_CLK_NS) > 0) ? (`QD_SPIKE_FS_NS / `QD_CLK_NS) : 1)
`define QD_FLT_HS_CYC    3'(((`QD_SPIKE_HS_NS / `QD_CLK_NS) > 0) ? (`QD_SPIKE_HS_NS / `QD_CLK_NS) : 1)
`define QD_STRAP_CAP_CYC 4'hf

`endif

// File: hw/qd_pkg.sv
// Types shared by the update port and its channel bank
package qd_pkg;

  // ============================================================
  // Load modes as carried in the control byte
  typedef enum logic [1:0] {
    QD_MODE_STORE = 2'h0,
    QD_MODE_LOAD  = 2'h1,
    QD_MODE_SYNC  = 2'h2,
    QD_MODE_BCAST = 2'h3
  } qd_mode_t;

  // Byte sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CTRL, ST_MSB, ST_LSB, ST_IGNORE} qd_state_t;

  // One channel update request
  typedef struct packed {
    qd_mode_t   mode;
    logic [1:0] pick;
    logic       pd;
    logic [7:0] code;
  } qd_upd_t;

  // One channel entry: code plus power-down flag
  typedef struct packed {
    logic [7:0] code;
    logic       pd;
  } qd_chan_t;

endpackage

// File: hw/qd_pin_filter.sv
// Two-flop pin synchroniser with a spike filter on every bit
`include "qd_consts.svh"

module qd_pin_filter
  import qd_pkg::*;
#(
  parameter int W = 6
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic         hs,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] clean
);

  // Shorter filter in high-speed so 60 ns clock highs still pass
  logic [2:0] flt_len;
  assign flt_len = hs ? `QD_FLT_HS_CYC : `QD_FLT_FS_CYC; // RULE_06

  genvar i;
  for (i = 0; i < W; i++) begin : g_bit
    logic       meta_r;
    logic       sync_r;
    logic       clean_r;
    logic [2:0] cnt_r;
    logic [2:0] cnt_nxt;
    // Count cycles that disagree with the filtered level
    assign cnt_nxt  = (sync_r != clean_r) ? 3'(cnt_r + 3'h1) : 3'h0;
    assign clean[i] = clean_r;
    // Reset high: an idle bus reads high, so no phantom edge at release
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        meta_r  <= 1'h1;
        sync_r  <= 1'h1;
        clean_r <= 1'h1;
        cnt_r   <= 3'h0;
      end else if (ce) begin
        meta_r <= pin[i];
        sync_r <= meta_r;
        if (cnt_nxt > flt_len) begin
          clean_r <= sync_r;
          cnt_r   <= 3'h0;
        end else begin
          cnt_r <= cnt_nxt;
        end
      end
    end
  end

endmodule

// File: hw/qd_chan_bank.sv
// Temporary and live registers of the four converter channels
module qd_chan_bank
  import qd_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       fire,
  input  wire qd_upd_t    upd,
  output logic [3:0][7:0] dac_code,
  output logic [3:0]      dac_pd
);

  qd_chan_t temp_r [4];
  qd_chan_t live_r [4];
  qd_chan_t entry;
  logic     bc_new;
  logic     bc_old;

  // Code is kept as plain unsigned binary
  assign entry  = '{code: upd.code, pd: upd.pd}; // RULE_24
  // Broadcast mode ignores the pick: high pick bit loads new data everywhere
  assign bc_new = (upd.mode == QD_MODE_BCAST) && upd.pick[1]; // RULE_23
  assign bc_old = (upd.mode == QD_MODE_BCAST) && !upd.pick[1];

  genvar c;
  for (c = 0; c < 4; c++) begin : g_ch
    logic hit;
    logic ld_tmp;
    logic ld_new;
    logic ld_old;
    assign hit    = (upd.pick == 2'(c)) && (upd.mode != QD_MODE_BCAST); // RULE_26
    assign ld_tmp = hit || bc_new;
    assign ld_new = (hit && (upd.mode != QD_MODE_STORE)) || bc_new; // RULE_23
    assign ld_old = (!hit && (upd.mode == QD_MODE_SYNC)) || bc_old; // RULE_23
    assign dac_code[c] = live_r[c].code;
    assign dac_pd[c]   = live_r[c].pd;
    // Outputs power up at code zero and stay there until a valid write
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        temp_r[c] <= '0;
        live_r[c] <= '0;
      end else if (ce && fire) begin
        if (ld_tmp) begin
          temp_r[c] <= entry;
        end
        if (ld_new) begin
          live_r[c] <= entry;
        end else if (ld_old) begin
          live_r[c] <= temp_r[c];
        end
      end
    end
  end

endmodule

// File: hw/qd_i2c_update_port.sv
// Two-wire serial update port of a four-channel 8-bit converter
// Notes on behaviour
// RULE_01: Start is SDA falling while SCL is high; an address byte follows.
// RULE_02: Stop is SDA rising while SCL is high; release SDA and wait idle.
// RULE_03: Master keeps SDA stable while SCL is high outside start and stop.
// RULE_04: Acknowledge a matching address by holding SDA low through the ninth clock.
// RULE_05: Every byte is eight bits plus one acknowledge bit, repeated freely.
// RULE_06: Work at standard, fast and high-speed rates; standard and fast match.
// RULE_07: Decode 7-bit addresses only; ignore 10-bit and general call.
// RULE_08: Master code 00001xxx is not acknowledged but switches to high-speed.
// RULE_09: Repeated start continues high-speed; a stop returns to standard/fast.
// RULE_10: Master uses repeated starts, not stops, to stay in high-speed.
// RULE_11: Master alone drives SCL, makes start and stop, sends addresses.
// RULE_12: First update needs address, control, MSB and LSB bytes in order.
// RULE_13: Acknowledge every received byte by pulling SDA low in the next clock.
// RULE_14: Update channels at the falling edge of the acknowledge after LSB.
// RULE_15: Control byte persists; each further MSB/LSB pair repeats the update.
// RULE_16: MSB byte is the whole 8-bit code; LSB bits are ignored.
// RULE_17: In high-speed, each later update takes 18 SCL cycles.
// RULE_18: Address byte is 10011, two device-select bits, then direction bit.
// RULE_19: Device-select pins are sampled after power-up and kept as address.
// RULE_20: Broadcast address acknowledged regardless of pins, for writes only.
// RULE_21: Control byte: extended address, load mode, unused, pick, power-down.
// RULE_22: Outside broadcast, extended bits must match extended pins or no update.
// RULE_23: Load mode 00 store, 01 store and load, 10 sync all, 11 broadcast.
// RULE_24: The 8-bit code is unsigned binary, 0 to 255.
// RULE_25: On address mismatch keep SDA released and ignore bytes until a start.
// RULE_26: Channel pick bits choose the channel in single-channel load modes.
`include "qd_consts.svh"

module qd_i2c_update_port
  import qd_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       scl_clk,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_n,
  input  wire logic       device_select_hi,
  input  wire logic       device_select_lo,
  input  wire logic       ext_select_hi,
  input  wire logic       ext_select_lo,
  output logic [3:0][7:0] dac_code,
  output logic [3:0]      dac_powerdown,
  output logic            update_strobe,
  output logic            hs_mode,
  output logic [7:0]      update_control
);

  // ============================================================
  // Decode helpers

  // Own address: fixed prefix then the two captured select bits
  function automatic logic is_own(input logic [7:0] b, input logic [1:0] sel);
    is_own = (b[7:1] == {`QD_ADDR_FIXED, sel}); // RULE_18
  endfunction

  // High-speed master code: 00001 followed by three free bits
  function automatic logic is_hs_code(input logic [7:0] b);
    is_hs_code = (b[7:3] == `QD_HS_CODE); // RULE_08
  endfunction

  // ============================================================
  // Declarations

  logic [5:0]  pin_raw;
  logic [5:0]  pin_clean;
  logic        scl_f;
  logic        sda_f;
  logic [1:0]  dsel_f;
  logic [1:0]  ext_f;
  logic        scl_q_r;
  logic        sda_q_r;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_det;
  logic        stop_det;
  logic [7:0]  link_shreg_r;
  logic [7:0]  rx_byte;
  qd_state_t   state_r;
  qd_state_t   state_nxt;
  logic [3:0]  bit_cnt_r;
  logic        ack_phase_r;
  logic        byte_done;
  logic        ack_end;
  logic        addr_own;
  logic        addr_bcast;
  logic        addr_hs;
  logic        ack_this;
  logic        sda_oe_n_r;
  logic        sda_out_r;
  logic        hs_mode_r;
  logic        bcast_r;
  logic [7:0]  ctrl_r;
  logic [7:0]  code_r;
  logic        ext_ok;
  logic        upd_allowed;
  logic        upd_pending_r;
  logic        upd_fire;
  logic        update_strobe_r;
  logic [1:0]  dsel_r;
  logic        dsel_ok_r;
  logic [3:0]  cap_cnt_r;
  qd_upd_t     upd;
  logic [3:0][7:0] bank_code;
  logic [3:0]  bank_pd;

  // ============================================================
  // Pin conditioning

  // Pins from outside pass two flops and a spike filter first, except scl_clk and the shifter's raw sda_in
  assign pin_raw = {scl_in, sda_in, device_select_hi, device_select_lo, ext_select_hi, ext_select_lo};

  qd_pin_filter #(
    .W (6)
  ) u_pins (
    .clock (clock),
    .rst_n (rst_n),
    .ce    (ce),
    .hs    (hs_mode_r),
    .pin   (pin_raw),
    .clean (pin_clean)
  );

  assign scl_f  = pin_clean[5];
  assign sda_f  = pin_clean[4];
  assign dsel_f = pin_clean[3:2];
  assign ext_f  = pin_clean[1:0];

  // Previous filtered levels for edge detection
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_r <= 1'h1;
      sda_q_r <= 1'h1;
    end else if (ce) begin
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
    end
  end

  // Bus events; SCL is only ever driven by the master
  assign scl_rise  = ce && scl_f && !scl_q_r; // RULE_11
  assign scl_fall  = ce && !scl_f && scl_q_r;
  assign start_det = ce && scl_f && scl_q_r && !sda_f && sda_q_r; // RULE_01
  assign stop_det  = ce && scl_f && scl_q_r && sda_f && !sda_q_r; // RULE_02

  // ============================================================
  // Link domain: bits shifted on the master's own SCL rising edge

  // Data is only valid while SCL is high, so the rising edge samples it
  always_ff @(posedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_shreg_r <= 8'h00;
    end else begin
      link_shreg_r <= {link_shreg_r[6:0], sda_in}; // RULE_03
    end
  end

  // The shifter is quiet from SCL falling until the next rise, far longer
  // than the filtered edge delay, so the word is read whole at that point
  assign rx_byte = link_shreg_r;

  // ============================================================
  // Power-up capture of the device-select pins

  // Wait for the filtered pins to settle, then hold them for good
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cap_cnt_r <= 4'h0;
      dsel_r    <= 2'h0;
      dsel_ok_r <= 1'h0;
    end else if (ce && !dsel_ok_r) begin
      cap_cnt_r <= 4'(cap_cnt_r + 4'h1);
      if (cap_cnt_r == `QD_STRAP_CAP_CYC) begin
        dsel_r    <= dsel_f; // RULE_19
        dsel_ok_r <= 1'h1;
      end
    end
  end

  // ============================================================
  // Byte framing

  // Eight data rises then the acknowledge clock, repeating per byte
  assign byte_done = scl_fall && !ack_phase_r && (bit_cnt_r == `QD_BYTE_BITS); // RULE_05
  assign ack_end   = scl_fall && ack_phase_r && (bit_cnt_r == `QD_ACK_RISES);

  // Counter is cleared by start and stop, so a stray rise cannot misalign it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r   <= 4'h0;
      ack_phase_r <= 1'h0;
    end else if (start_det || stop_det) begin
      bit_cnt_r   <= 4'h0;
      ack_phase_r <= 1'h0;
    end else if (scl_rise && (bit_cnt_r != `QD_ACK_RISES)) begin
      bit_cnt_r <= 4'(bit_cnt_r + 4'h1); // RULE_05
    end else if (byte_done) begin
      ack_phase_r <= 1'h1;
    end else if (ack_end) begin
      ack_phase_r <= 1'h0;
      bit_cnt_r   <= 4'h0;
    end
  end

  // ============================================================
  // Address and byte decode

  // Only 7-bit forms are compared; general call and 10-bit never match
  assign addr_own   = dsel_ok_r && is_own(rx_byte, dsel_r); // RULE_07
  assign addr_bcast = (rx_byte == `QD_BCAST_ADDR); // RULE_20
  assign addr_hs    = is_hs_code(rx_byte);

  // Which received bytes earn an acknowledge
  always_comb begin
    ack_this = 1'h0;
    case (state_r)
      ST_ADDR: ack_this = !addr_hs && (addr_own || addr_bcast); // RULE_04
      ST_CTRL: ack_this = 1'h1; // RULE_13
      ST_MSB:  ack_this = 1'h1; // RULE_13
      ST_LSB:  ack_this = 1'h1; // RULE_13
      default: ack_this = 1'h0;
    endcase
  end

  // ============================================================
  // Sequencer

  // Address, control, then MSB/LSB pairs looping until start or stop
  always_comb begin
    state_nxt = state_r;
    if (stop_det) begin
      state_nxt = ST_IDLE; // RULE_02
    end else if (start_det) begin
      state_nxt = ST_ADDR; // RULE_01
    end else if (byte_done) begin
      case (state_r)
        ST_ADDR: begin
          if (addr_hs) begin
            state_nxt = ST_IGNORE; // RULE_08
          end else if (addr_own && (rx_byte[0] != `QD_RW_READ)) begin
            state_nxt = ST_CTRL; // RULE_12
          end else if (addr_bcast) begin
            state_nxt = ST_CTRL; // RULE_20
          end else begin
            state_nxt = ST_IGNORE; // RULE_25
          end
        end
        ST_CTRL: state_nxt = ST_MSB; // RULE_12
        ST_MSB:  state_nxt = ST_LSB;
        ST_LSB:  state_nxt = ST_MSB; // RULE_15
        default: state_nxt = state_r;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // ============================================================
  // SDA drive

  // Pull low from the fall after bit eight to the fall of the ninth clock,
  // so the line is low through the whole ninth high phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe_n_r <= 1'h1;
      sda_out_r  <= 1'h0;
    end else if (ce) begin
      sda_out_r <= 1'h0;
      if (start_det || stop_det) begin
        sda_oe_n_r <= 1'h1; // RULE_02
      end else if (byte_done && ack_this) begin
        sda_oe_n_r <= 1'h0; // RULE_04
      end else if (ack_end) begin
        sda_oe_n_r <= 1'h1; // RULE_13
      end
    end
  end

  // ============================================================
  // Speed mode

  // Master code selects high-speed; only a stop leaves it, repeated
  // starts keep it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      hs_mode_r <= 1'h0;
    end else if (ce) begin
      if (stop_det) begin
        hs_mode_r <= 1'h0; // RULE_09
      end else if (byte_done && (state_r == ST_ADDR) && addr_hs) begin
        hs_mode_r <= 1'h1; // RULE_08
      end
    end
  end

  // ============================================================
  // Control and data capture

  // Control survives repeated pairs; broadcast flag lives per transfer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r  <= `QD_CTL_RESET;
      code_r  <= 8'h00;
      bcast_r <= 1'h0;
    end else if (ce) begin
      if (start_det || stop_det) begin
        bcast_r <= 1'h0;
      end else if (byte_done) begin
        if (state_r == ST_ADDR) begin
          bcast_r <= addr_bcast;
        end
        if (state_r == ST_CTRL) begin
          ctrl_r <= rx_byte; // RULE_21
        end
        if (state_r == ST_MSB) begin
          code_r <= rx_byte; // RULE_16
        end
      end
    end
  end

  // Extended bits must match the pins unless broadcasting
  assign ext_ok      = ({ctrl_r[`QD_CTL_EXT_HI], ctrl_r[`QD_CTL_EXT_LO]} == ext_f);
  assign upd_allowed = ext_ok || bcast_r || (upd.mode == QD_MODE_BCAST); // RULE_22

  // Update request built from the stored control and MSB code only
  assign upd.mode = qd_mode_t'(ctrl_r[`QD_CTL_MODE_HI:`QD_CTL_MODE_LO]); // RULE_23
  assign upd.pick = ctrl_r[`QD_CTL_PICK_HI:`QD_CTL_PICK_LO]; // RULE_26
  assign upd.pd   = ctrl_r[`QD_CTL_PD];
  assign upd.code = code_r; // RULE_16

  // ============================================================
  // Update timing

  // Armed when the LSB byte lands, fired on the fall ending its acknowledge
  assign upd_fire = ack_end && upd_pending_r; // RULE_14

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      upd_pending_r   <= 1'h0;
      update_strobe_r <= 1'h0;
    end else if (ce) begin
      update_strobe_r <= upd_fire;
      if (start_det || stop_det || ack_end) begin
        upd_pending_r <= 1'h0;
      end else if (byte_done && (state_r == ST_LSB)) begin
        upd_pending_r <= upd_allowed; // RULE_22
      end
    end
  end

  qd_chan_bank u_bank (
    .clock    (clock),
    .rst_n    (rst_n),
    .ce       (ce),
    .fire     (upd_fire),
    .upd      (upd),
    .dac_code (bank_code),
    .dac_pd   (bank_pd)
  );

  // ============================================================
  // Outputs, all from flops

  assign sda_out        = sda_out_r;
  assign sda_oe_n       = sda_oe_n_r;
  assign dac_code       = bank_code;
  assign dac_powerdown  = bank_pd;
  assign update_strobe  = update_strobe_r;
  assign hs_mode        = hs_mode_r;
  assign update_control = ctrl_r;

  // ============================================================
  // Checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Helper: SCL rises since the previous update inside one transfer
  logic [4:0] rise_cnt_r;
  logic       fired_once_r;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rise_cnt_r   <= 5'h00;
      fired_once_r <= 1'h0;
    end else if (start_det || stop_det) begin
      rise_cnt_r   <= 5'h00;
      fired_once_r <= 1'h0;
    end else if (upd_fire) begin
      rise_cnt_r   <= 5'h00;
      fired_once_r <= 1'h1;
    end else if (scl_rise && (rise_cnt_r != 5'h1f)) begin
      rise_cnt_r <= 5'(rise_cnt_r + 5'h01);
    end
  end

  property p_start_addr;
    start_det |=> (state_r == ST_ADDR) && (bit_cnt_r == 4'h0) && sda_oe_n;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start did not open an address byte"); // RULE_01

  property p_stop_idle;
    stop_det |=> (state_r == ST_IDLE) && sda_oe_n ##1 sda_oe_n;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop did not release the bus"); // RULE_02

  property p_own_ack;
    byte_done && (state_r == ST_ADDR) && addr_own && !addr_hs |=> !sda_oe_n && ack_phase_r;
  endproperty
  a_own_ack: assert property (p_own_ack) else $error("matching address not acknowledged"); // RULE_04

  property p_ack_window;
    !sda_oe_n |-> ack_phase_r && (bit_cnt_r >= `QD_BYTE_BITS);
  endproperty
  a_ack_window: assert property (p_ack_window) else $error("SDA pulled low outside an acknowledge"); // RULE_13

  property p_gc_ignored;
    byte_done && (state_r == ST_ADDR) && (rx_byte == 8'h00) |=> sda_oe_n && (state_r == ST_IGNORE);
  endproperty
  a_gc_ignored: assert property (p_gc_ignored) else $error("general call answered"); // RULE_07

  property p_hs_enter;
    byte_done && (state_r == ST_ADDR) && addr_hs |=> hs_mode && sda_oe_n;
  endproperty
  a_hs_enter: assert property (p_hs_enter) else $error("master code handled wrongly"); // RULE_08

  property p_hs_exit;
    hs_mode && stop_det |=> !hs_mode;
  endproperty
  a_hs_exit: assert property (p_hs_exit) else $error("stop did not leave high-speed"); // RULE_09

  property p_bcast_read;
    byte_done && (state_r == ST_ADDR) && (rx_byte == (`QD_BCAST_ADDR | 8'h01)) |=> sda_oe_n;
  endproperty
  a_bcast_read: assert property (p_bcast_read) else $error("broadcast read acknowledged"); // RULE_20

  property p_update_edge;
    upd_fire |-> (state_r == ST_MSB) ##1 update_strobe && !ack_phase_r && sda_oe_n;
  endproperty
  a_update_edge: assert property (p_update_edge) else $error("update not at acknowledge fall"); // RULE_14

  property p_ctrl_hold;
    byte_done && (state_r != ST_CTRL) |=> $stable(update_control);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control byte changed outside its slot"); // RULE_15

  property p_gate;
    byte_done && (state_r == ST_LSB) && !upd_allowed |=> !upd_pending_r ##1 !update_strobe;
  endproperty
  a_gate: assert property (p_gate) else $error("update despite extended address mismatch"); // RULE_22

  property p_pace;
    upd_fire && fired_once_r && hs_mode |-> (rise_cnt_r == `QD_UPDATE_RISES);
  endproperty
  a_pace: assert property (p_pace) else $error("later update not 18 clocks apart"); // RULE_17

  property p_ignore_quiet;
    (state_r == ST_IGNORE) |-> sda_oe_n && !upd_pending_r;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) else $error("ignored transfer touched the bus"); // RULE_25

endmodule

// File: dv/qd_i2c_master.sv
// Two-wire bus master model that drives SCL and pulls SDA low
module qd_i2c_master (
  input  wire logic clock,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // Quarter bit in clocks; slower than the link rate so the low phase outlasts the pin filter lag
  localparam int Q = 16;
  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Start or repeated start: SDA falls while SCL is high
  task automatic start();
    sda_low <= 1'b0;
    wt(Q);
    scl <= 1'b1;
    wt(Q);
    sda_low <= 1'b1;
    wt(Q);
    scl <= 1'b0;
    wt(Q);
  endtask
  // One byte MSB first, then the ninth clock; ack only if SDA low at both ends of the high phase
  task automatic put(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low <= !b[i];
      wt(Q);
      scl <= 1'b1;
      wt(2 * Q);
      scl <= 1'b0;
      wt(Q);
    end
    sda_low <= 1'b0;
    wt(Q);
    scl <= 1'b1;
    wt(1);
    ack = !sda;
    wt(2 * Q - 1);
    ack = ack & !sda;
    scl <= 1'b0;
    wt(Q);
  endtask
  // Stop: SDA rises while SCL is high
  task automatic stop();
    sda_low <= 1'b1;
    wt(Q);
    scl <= 1'b1;
    wt(Q);
    sda_low <= 1'b0;
    wt(2 * Q);
  endtask
endmodule

// File: dv/tb_qd_i2c_update_port.sv
// Self-checking bench for the two-wire update port
module tb_qd_i2c_update_port;
  timeunit 1ns;
  timeprecision 1ps;
  import qd_pkg::*;
  logic            clock = 1'b0;
  logic            rst_n = 1'b0;
  logic            scl, sda_low, sda_out, sda_oe_n, update_strobe, hs_mode, k;
  logic [3:0][7:0] dac_code;
  logic [3:0]      dac_powerdown;
  logic [7:0]      update_control;
  logic            ext_hi = 1'b1;
  logic            ext_lo = 1'b0;
  logic            ce_on = 1'b1;
  int              err_total = 0;
  int              comparisons = 0;
  int              n_upd = 0;
  // Open-drain SDA with pull-up; while enabled the port puts its sda_out value on the line
  wire sda = (sda_low | (!sda_oe_n & !sda_out)) ? 1'b0 : 1'b1;
  always #4 clock = !clock;
  // Count one-cycle update pulses
  always @(posedge clock) if (update_strobe === 1'b1) n_upd++;
  // Straps 01, extended pins 10
  qd_i2c_update_port uut (.clock(clock), .rst_n(rst_n), .ce(ce_on), .scl_clk(scl), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .device_select_hi(1'b0), .device_select_lo(1'b1),
    .ext_select_hi(ext_hi), .ext_select_lo(ext_lo), .dac_code(dac_code), .dac_powerdown(dac_powerdown),
    .update_strobe(update_strobe), .hs_mode(hs_mode), .update_control(update_control));
  qd_i2c_master m (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
  // ============================================================
  // Checks and transfers
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("Counts: %0d mismatches in %0d comparisons", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Address, control, then one or two MSB/LSB pairs; the second pair carries the inverted code
  task automatic wr(input logic [7:0] a, c, d, input logic ea, input int np);
    m.start();
    m.put(a, k);
    chk("addr ack", {7'h0, ea}, {7'h0, k});
    if (k === 1'b1) begin
      m.put(c, k);
      m.put(d, k);
      m.put(8'hff, k);
      if (np > 1) begin
        m.put(~d, k);
        m.put(8'h00, k);
      end
      chk("last ack", 8'h01, {7'h0, k});
    end
    m.stop();
    m.wt(40);
  endtask
  // ============================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    chk("ctl reset", 8'h00, update_control);
    chk("sda idle", 8'h01, {7'h0, sda_oe_n});
    m.wt(40);
    wr(8'h9a, 8'h94, 8'ha5, 1'b1, 1);
    chk("ch2", 8'ha5, dac_code[2]);
    chk("ctl", 8'h94, update_control);
    wr(8'h9a, 8'h94, 8'h3c, 1'b1, 2);
    chk("ch2 again", 8'hc3, dac_code[2]);
    wr(8'h9a, 8'h82, 8'h77, 1'b1, 1);
    chk("ch1 held", 8'h00, dac_code[1]);
    wr(8'h9a, 8'ha0, 8'h11, 1'b1, 1);
    chk("ch0 sync", 8'h11, dac_code[0]);
    chk("ch1 sync", 8'h77, dac_code[1]);
    wr(8'h98, 8'h94, 8'h5a, 1'b0, 1);
    wr(8'h00, 8'h94, 8'h5a, 1'b0, 1);
    wr(8'h91, 8'h94, 8'h5a, 1'b0, 1);
    chk("ch2 kept", 8'hc3, dac_code[2]);
    wr(8'h9a, 8'h16, 8'h55, 1'b1, 1);
    chk("ch3 dropped", 8'h00, dac_code[3]);
    wr(8'h90, 8'h16, 8'h66, 1'b1, 1);
    chk("ch3 bcast", 8'h66, dac_code[3]);
    wr(8'h9a, 8'h34, 8'h99, 1'b1, 1);
    chk("ch0 all", 8'h99, dac_code[0]);
    m.start();
    m.put(8'h08, k);
    chk("hs code ack", 8'h00, {7'h0, k});
    chk("hs on", 8'h01, {7'h0, hs_mode});
    wr(8'h9a, 8'h95, 8'h00, 1'b1, 2);
    chk("ch2 full", 8'hff, dac_code[2]);
    chk("pd", 8'h04, {4'h0, dac_powerdown});
    chk("hs off", 8'h00, {7'h0, hs_mode});
    chk("strobes", 8'h09, 8'(n_upd));
    close_out();
  end
  // Watchdog well beyond the roughly 25000 cycles of traffic
  initial begin
    m.wt(60000);
    err_total++;
    close_out();
  end
endmodule
